// [logic/rfs_pkg.sv]
// Shared constants and types for the regulator fault supervisor
// -----------------------------------------------------------------------------
// How it works
// - Power-good stays low when shut down and during soft-start until limits are met.
// - Power-good drops on any OV, UV, OC, supply loss or low enable.
// - Any triggered fault latches an off state with power-good held low.
// - Toggling enable or supply clears the latch and starts a fresh soft-start.
// - After overvoltage only a supply drop restarts; enable toggles are ignored.
// - Core overcurrent acts only after persisting continuously for 100 us.
// - Core short-circuit at 2.25x trip level acts immediately, unqualified.
// - Core overcurrent compares five times sense voltage to trip pin over six.
// - Bridge overcurrent flags when low-side drop exceeds 10 uA across trip resistor.
// - Overcurrent on any outputs shuts all regulators, tri-states drivers, drops power-good.
// - No automatic restart after overcurrent; only enable or supply toggle clears it.
// - Output above 1.8 V trips overvoltage, drops power-good, turns its low-side on.
// - Low-side stays on until output below 0.85 V, then off; repeats on retrip.
// - Overvoltage watch stays active while enabled, even after other faults latched.
// - Undervoltage latches when output sits 295 mV under target for 205 us.
// - Undervoltage fault switches off all drivers and drops power-good.
// - Undervoltage is judged independently of overcurrent; either alone faults.
// -----------------------------------------------------------------------------
package rfs_pkg;

    // -------------------------------------------------------------------------
    // Clock and qualification times
    // -------------------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int OC_QUAL_US = 100;
    localparam int UV_QUAL_US = 205;
    localparam int OC_QUAL_CYC = OC_QUAL_US * CLK_MHZ;
    localparam int UV_QUAL_CYC = UV_QUAL_US * CLK_MHZ;
    localparam int QCNT_W = 16;

    // -------------------------------------------------------------------------
    // Analog thresholds realised by the external comparators
    // -------------------------------------------------------------------------
    localparam int OV_TRIP_MV = 1800;
    localparam int OV_RELEASE_MV = 850;
    localparam int UV_MARGIN_MV = 295;
    localparam int CORE_SENSE_GAIN = 5;
    localparam int CORE_SET_DIV = 6;
    localparam int CORE_SC_X100 = 225;
    localparam int BRIDGE_SRC_UA = 10;

    // -------------------------------------------------------------------------
    // Outputs and input bundle layout
    // -------------------------------------------------------------------------
    localparam int N_CORE = 2;
    localparam int N_OUT = 3;
    localparam int SYNC_W = 14;

    // Driver commands
    localparam logic [1:0] DRV_SWITCH = 2'h0;
    localparam logic [1:0] DRV_TRISTATE = 2'h1;
    localparam logic [1:0] DRV_ALL_OFF = 2'h2;
    localparam logic [1:0] DRV_LOW_ON = 2'h3;

    localparam logic PG_OE_RST = 1'h1;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_SOFTSTART,
        ST_RUN,
        ST_OC_LATCH,
        ST_UV_LATCH,
        ST_OV_LATCH
    } rfs_state_e;

endpackage

// [logic/rfs_qual.sv]
// Persistence timer: output rises after its condition holds LIMIT cycles
`timescale 1ns/1ps
module rfs_qual #(
    parameter logic [15:0] LIMIT = 16'h0010
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cond,
    output logic qualified
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;

    assign cnt_next = !cond ? 16'h0000 : (cnt_reg == LIMIT) ? cnt_reg : cnt_reg + 16'h0001;
    assign qualified = cond && (cnt_reg == LIMIT);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_reg <= 16'h0000;
        else
            cnt_reg <= cnt_next;
    end

    a_qual_needs_hold: assert property (
        @(posedge clk) disable iff (rst) qualified |-> $past(cond) && cnt_reg == LIMIT)
        else $error("qualified without a held condition");
    a_qual_restart: assert property (
        @(posedge clk) disable iff (rst) !cond |=> cnt_reg == 16'h0000)
        else $error("timer did not restart on drop");
endmodule // rfs_qual

// [logic/rfs_supervisor.sv]
// Fault supervisor: qualifies comparators, latches faults, drives power-good and drivers
`timescale 1ns/1ps
module rfs_supervisor #(
    parameter int OC_QUAL_CYC = rfs_pkg::OC_QUAL_CYC,
    parameter int UV_QUAL_CYC = rfs_pkg::UV_QUAL_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable_in,
    input wire logic supply_ok,
    input wire logic soft_start_done,
    input wire logic [1:0] core_oc_cmp,
    input wire logic [1:0] core_sc_cmp,
    input wire logic bridge_oc_cmp,
    input wire logic [2:0] ov_cmp,
    input wire logic [2:0] ov_clear_cmp,
    input wire logic [2:0] uv_cmp,
    input wire logic output_in_regulation_flag_i,
    output logic output_in_regulation_flag_o,
    output logic output_in_regulation_flag_oe,
    output logic soft_start_go,
    output logic [1:0] drv_cmd_core0,
    output logic [1:0] drv_cmd_core1,
    output logic [1:0] drv_cmd_bridge,
    output logic fault_oc,
    output logic fault_uv,
    output logic fault_ov,
    output logic pg_pin_low
);
    localparam int QW = rfs_pkg::QCNT_W;
    localparam logic [15:0] OC_LIM = QW'(OC_QUAL_CYC);
    localparam logic [15:0] UV_LIM = QW'(UV_QUAL_CYC);

    // -------------------------------------------------------------------------
    // Input synchronisation
    // -------------------------------------------------------------------------
    logic [rfs_pkg::SYNC_W-1:0] raw_bus;
    logic [rfs_pkg::SYNC_W-1:0] sync_bus;
    logic [1:0] core_oc_s;
    logic [1:0] core_sc_s;
    logic bridge_oc_s;
    logic [2:0] ov_s;
    logic [2:0] ov_clr_s;
    logic [2:0] uv_s;

    assign raw_bus = {core_oc_cmp, core_sc_cmp, bridge_oc_cmp, ov_cmp, ov_clear_cmp, uv_cmp};

    rfs_sync #(
        .W(rfs_pkg::SYNC_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d(raw_bus),
        .q(sync_bus)
    );

    assign {core_oc_s, core_sc_s, bridge_oc_s, ov_s, ov_clr_s, uv_s} = sync_bus;

    // -------------------------------------------------------------------------
    // State and qualification
    // -------------------------------------------------------------------------
    rfs_pkg::rfs_state_e state_reg;
    rfs_pkg::rfs_state_e state_next;
    logic active;
    logic running;
    logic [1:0] core_oc_q;
    logic [2:0] uv_q;
    logic oc_trip;
    logic uv_trip;
    logic ov_watch;
    logic ov_trip;
    logic [2:0] ov_act_reg;
    logic [2:0] ov_act_next;

    assign active = (state_reg == rfs_pkg::ST_SOFTSTART) || (state_reg == rfs_pkg::ST_RUN);
    assign running = (state_reg == rfs_pkg::ST_RUN);

    genvar gi;
    generate
        for (gi = 0; gi < rfs_pkg::N_CORE; gi++)
        begin : g_core_oc
            rfs_qual #(
                .LIMIT(OC_LIM)
            ) u_oc_qual (
                .clk(clk),
                .rst(rst),
                .cond(core_oc_s[gi] && active),
                .qualified(core_oc_q[gi])
            );
        end
        for (gi = 0; gi < rfs_pkg::N_OUT; gi++)
        begin : g_uv
            rfs_qual #(
                .LIMIT(UV_LIM)
            ) u_uv_qual (
                .clk(clk),
                .rst(rst),
                .cond(uv_s[gi] && running),
                .qualified(uv_q[gi])
            );
        end
    endgenerate

    assign oc_trip = active && ((|core_oc_q) || (|core_sc_s) || bridge_oc_s);
    assign uv_trip = running && (|uv_q);

    // OV watched in every enabled state
    assign ov_watch = supply_ok && (enable_in || state_reg == rfs_pkg::ST_OV_LATCH);
    assign ov_trip = ov_watch && (|ov_s);

    // clamp until below release, set wins
    assign ov_act_next = ov_watch ? (ov_s | (ov_act_reg & ~ov_clr_s)) : 3'h0;

    always_comb
    begin
        state_next = state_reg;
        if (!supply_ok)
            // only route out of OV latch
            state_next = rfs_pkg::ST_OFF;
        else
        begin
            unique case (state_reg)
                rfs_pkg::ST_OFF:
                begin
                    // OV before start
                    // A stale overvoltage must not launch a soft-start into a shorted output
                    if (ov_trip)
                        state_next = rfs_pkg::ST_OV_LATCH;
                    else if (enable_in)
                        state_next = rfs_pkg::ST_SOFTSTART;
                end
                rfs_pkg::ST_OV_LATCH:
                begin
                    state_next = rfs_pkg::ST_OV_LATCH;
                end
                default:
                begin
                    if (ov_trip)
                        state_next = rfs_pkg::ST_OV_LATCH;
                    // enable low clears OC or UV
                    else if (!enable_in)
                        state_next = rfs_pkg::ST_OFF;
                    else if (oc_trip)
                        state_next = rfs_pkg::ST_OC_LATCH;
                    else if (uv_trip)
                        state_next = rfs_pkg::ST_UV_LATCH;
                    // run only with all outputs in limits
                    else if (state_reg == rfs_pkg::ST_SOFTSTART && soft_start_done && !(|uv_s))
                        state_next = rfs_pkg::ST_RUN;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Driver command decode
    // -------------------------------------------------------------------------
    function automatic logic [1:0] drv_code(input rfs_pkg::rfs_state_e st, input logic clamp);
        logic [1:0] code;
        code = rfs_pkg::DRV_TRISTATE;
        if (clamp)
            code = rfs_pkg::DRV_LOW_ON;
        else
        begin
            unique case (st)
                rfs_pkg::ST_SOFTSTART: code = rfs_pkg::DRV_SWITCH;
                rfs_pkg::ST_RUN: code = rfs_pkg::DRV_SWITCH;
                rfs_pkg::ST_OC_LATCH: code = rfs_pkg::DRV_TRISTATE;
                rfs_pkg::ST_UV_LATCH: code = rfs_pkg::DRV_ALL_OFF;
                rfs_pkg::ST_OV_LATCH: code = rfs_pkg::DRV_ALL_OFF;
                rfs_pkg::ST_OFF: code = rfs_pkg::DRV_TRISTATE;
            endcase
        end
        return code;
    endfunction

    logic [1:0] drv_next [rfs_pkg::N_OUT];
    logic [1:0] drv_reg [rfs_pkg::N_OUT];

    generate
        for (gi = 0; gi < rfs_pkg::N_OUT; gi++)
        begin : g_drv
            assign drv_next[gi] = drv_code(state_next, ov_act_next[gi]);
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    drv_reg[gi] <= rfs_pkg::DRV_TRISTATE;
                else
                    drv_reg[gi] <= drv_next[gi];
            end
        end
    endgenerate

    assign drv_cmd_core0 = drv_reg[0];
    assign drv_cmd_core1 = drv_reg[1];
    assign drv_cmd_bridge = drv_reg[2];

    // -------------------------------------------------------------------------
    // Power-good and status
    // -------------------------------------------------------------------------
    logic pg_oe_reg;
    logic pg_oe_next;
    logic go_reg;

    // any fault or disable pulls low
    assign pg_oe_next = !(state_next == rfs_pkg::ST_RUN) || (|ov_act_next);

    // Flag is open drain: driven only low, external pull-up releases it
    assign output_in_regulation_flag_o = 1'h0;
    assign output_in_regulation_flag_oe = pg_oe_reg;
    assign pg_pin_low = !output_in_regulation_flag_i;
    assign soft_start_go = go_reg;
    assign fault_oc = (state_reg == rfs_pkg::ST_OC_LATCH);
    assign fault_uv = (state_reg == rfs_pkg::ST_UV_LATCH);
    assign fault_ov = (state_reg == rfs_pkg::ST_OV_LATCH);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= rfs_pkg::ST_OFF;
            ov_act_reg <= 3'h0;
            pg_oe_reg <= rfs_pkg::PG_OE_RST;
            go_reg <= 1'h0;
        end
        else
        begin
            state_reg <= state_next;
            ov_act_reg <= ov_act_next;
            pg_oe_reg <= pg_oe_next;
            go_reg <= (state_reg == rfs_pkg::ST_OFF) && (state_next == rfs_pkg::ST_SOFTSTART);
        end
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    a_pg_low_ramp: assert property (
        @(posedge clk) disable iff (rst)
        state_reg != rfs_pkg::ST_RUN |-> output_in_regulation_flag_oe)
        else $error("power-good released outside run");
    a_pg_low_disable: assert property (
        @(posedge clk) disable iff (rst)
        (!enable_in && state_reg != rfs_pkg::ST_OFF && !(|ov_s)) |=> output_in_regulation_flag_oe)
        else $error("power-good not low after disable");
    a_fault_latch_hold: assert property (
        @(posedge clk) disable iff (rst)
        (fault_oc && enable_in && supply_ok && !(|ov_s)) |=> fault_oc && output_in_regulation_flag_oe)
        else $error("overcurrent latch did not hold");
    a_restart_pulse: assert property (
        @(posedge clk) disable iff (rst)
        (state_reg == rfs_pkg::ST_OFF && enable_in && supply_ok && !(|ov_s))
            |=> soft_start_go ##1 !soft_start_go)
        else $error("restart pulse missing");
    a_ov_ignores_en: assert property (
        @(posedge clk) disable iff (rst)
        (fault_ov && supply_ok) |=> fault_ov)
        else $error("overvoltage latch left without supply drop");
    a_sc_immediate: assert property (
        @(posedge clk) disable iff (rst)
        ((|core_sc_s) && active && enable_in && supply_ok && !(|ov_s)) |=> fault_oc)
        else $error("short circuit not acted on at once");
    a_oc_tristate: assert property (
        @(posedge clk) disable iff (rst)
        (fault_oc && ov_act_reg == 3'h0) |-> drv_cmd_core0 == rfs_pkg::DRV_TRISTATE
            && drv_cmd_bridge == rfs_pkg::DRV_TRISTATE)
        else $error("drivers not tri-stated on overcurrent");
    a_ov_clamp_on: assert property (
        @(posedge clk) disable iff (rst)
        (ov_watch && ov_s[2]) |=> drv_cmd_bridge == rfs_pkg::DRV_LOW_ON && fault_ov)
        else $error("low-side clamp missing on overvoltage");
    a_ov_release: assert property (
        @(posedge clk) disable iff (rst)
        (ov_act_reg[0] && ov_clr_s[0] && !ov_s[0] && ov_watch) |=> !ov_act_reg[0]
            && drv_cmd_core0 != rfs_pkg::DRV_LOW_ON)
        else $error("clamp not released below threshold");
    a_uv_all_off: assert property (
        @(posedge clk) disable iff (rst)
        (fault_uv && ov_act_reg == 3'h0) |-> drv_cmd_core1 == rfs_pkg::DRV_ALL_OFF
            && output_in_regulation_flag_oe)
        else $error("drivers not off on undervoltage");
endmodule // rfs_supervisor

// [logic/rfs_sync.sv]
// Two-stage synchroniser for a bundle of comparator levels
`timescale 1ns/1ps
module rfs_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // rfs_sync

// [tb/rfs_pg_model.sv]
// Open-drain power-good wire with its pull-up, as seen by the system monitor
`timescale 1ns/1ps
module rfs_pg_model (
    input wire logic clk,
    input wire logic pg_oe,
    input wire logic pg_o,
    output logic pg_wire,
    output logic pg_good_reg
);
    // -------------------------------------------------------------------------
    // Wire level
    // -------------------------------------------------------------------------
    // pull-up when released
    assign pg_wire = pg_oe ? pg_o : 1'b1;

    // Monitor samples the wire once per cycle
    always_ff @(posedge clk)
    begin
        pg_good_reg <= pg_wire;
    end
endmodule // rfs_pg_model

// [tb/tb.sv]
// Self-checking bench for the regulator fault supervisor
`timescale 1ns/1ps
module tb;
    localparam int OCQ = 20;
    localparam int UVQ = 30;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic enable_in = 1'b0;
    logic supply_ok = 1'b0;
    logic soft_start_done = 1'b0;
    logic [1:0] core_oc_cmp = 2'h0;
    logic [1:0] core_sc_cmp = 2'h0;
    logic bridge_oc_cmp = 1'b0;
    logic [2:0] ov_cmp = 3'h0;
    logic [2:0] ov_clear_cmp = 3'h0;
    logic [2:0] uv_cmp = 3'h0;
    logic pg_wire, pg_good_reg, pg_o, pg_oe, go, f_oc, f_uv, f_ov, pg_low;
    logic [1:0] d0, d1, d2;
    logic [31:0] seed = 32'h79BC;
    int errors = 0;
    int checks = 0;
    int k;
    int n;

    always #4 clk = ~clk;

    rfs_supervisor #(.OC_QUAL_CYC(OCQ), .UV_QUAL_CYC(UVQ)) dut (.clk(clk), .rst(rst),
        .enable_in(enable_in), .supply_ok(supply_ok), .soft_start_done(soft_start_done),
        .core_oc_cmp(core_oc_cmp), .core_sc_cmp(core_sc_cmp), .bridge_oc_cmp(bridge_oc_cmp),
        .ov_cmp(ov_cmp), .ov_clear_cmp(ov_clear_cmp), .uv_cmp(uv_cmp),
        .output_in_regulation_flag_i(pg_wire), .output_in_regulation_flag_o(pg_o),
        .output_in_regulation_flag_oe(pg_oe), .soft_start_go(go), .drv_cmd_core0(d0),
        .drv_cmd_core1(d1), .drv_cmd_bridge(d2), .fault_oc(f_oc), .fault_uv(f_uv),
        .fault_ov(f_ov), .pg_pin_low(pg_low));

    rfs_pg_model sysmon (.clk(clk), .pg_oe(pg_oe), .pg_o(pg_o), .pg_wire(pg_wire),
        .pg_good_reg(pg_good_reg));

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Clamped output pulls low, the others sit switched off
    function automatic logic [1:0] ov_drv(input int out, input int hot);
        return (out == hot) ? rfs_pkg::DRV_LOW_ON : rfs_pkg::DRV_ALL_OFF;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // Bounded wait on one of the design's flags: 0 oc, 1 uv, 2 ov, 3 go
    task automatic wait_flag(input int sel, input int lim);
        logic f;
        for (int i = 0; i < lim; i++)
        begin
            tick(1);
            f = (sel == 0) ? f_oc : (sel == 1) ? f_uv : (sel == 2) ? f_ov : go;
            if (f === 1'b1)
                break;
        end
    endtask

    task automatic quiet();
        @(posedge clk);
        {core_oc_cmp, core_sc_cmp, bridge_oc_cmp} <= 5'h00;
        {ov_cmp, ov_clear_cmp, uv_cmp} <= 9'h000;
        soft_start_done <= 1'b0;
    endtask

    task automatic bring_up();
        quiet();
        // Let the cleared comparators pass both sync stages before enabling
        repeat (3) @(posedge clk);
        enable_in <= 1'b1;
        supply_ok <= 1'b1;
        wait_flag(3, 10);
        check(go, 1'b1);
        check({d0, d1, d2}, 6'h00);
        tick(3);
        check(pg_oe, 1'b1);
        @(posedge clk);
        soft_start_done <= 1'b1;
        tick(4);
        check({pg_oe, pg_wire, pg_low, pg_good_reg}, 4'h5);
    endtask

    task automatic restart_by(input logic by_supply);
        @(posedge clk);
        if (by_supply)
            supply_ok <= 1'b0;
        else
            enable_in <= 1'b0;
        tick(4);
        bring_up();
    endtask

    task end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #60000;
        errors++;
        end_of_test();
    end

    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        // shut down holds flag low, drivers floated
        check({pg_oe, d0, d1, d2}, 7'h55);
        bring_up();
        @(posedge clk);
        enable_in <= 1'b0;
        tick(4);
        check({pg_oe, pg_o, pg_wire}, 3'h4);
        bring_up();
        // Random short overcurrent bursts that must never qualify
        for (int r = 0; r < 4; r++)
        begin
            seed = lfsr_next(seed);
            n = 1 + seed[3:0];
            @(posedge clk);
            core_oc_cmp <= 2'h1 << r[0];
            repeat (n) @(posedge clk);
            core_oc_cmp <= 2'h0;
            tick(6);
            check(f_oc, 1'b0);
        end
        @(posedge clk);
        core_oc_cmp <= 2'h2;
        tick(OCQ - 4);
        check(f_oc, 1'b0);
        wait_flag(0, 12);
        tick(2);
        check({f_oc, pg_oe, d0, d1, d2}, 8'hD5);
        @(posedge clk);
        core_oc_cmp <= 2'h0;
        tick(30);
        check(f_oc, 1'b1);
        restart_by(1'b0);
        // Fast short-circuit trips with no qualification
        for (k = 0; k < 2; k++)
        begin
            @(posedge clk);
            core_sc_cmp <= 2'h1 << k;
            tick(5);
            check(f_oc, 1'b1);
            restart_by(k[0]);
        end
        @(posedge clk);
        bridge_oc_cmp <= 1'b1;
        wait_flag(0, OCQ + 8);
        check({f_oc, d2}, 3'h5);
        restart_by(1'b0);
        // Undervoltage on every output, with overcurrent silent
        for (k = 0; k < 3; k++)
        begin
            @(posedge clk);
            uv_cmp <= 3'h1 << k;
            tick(UVQ - 4);
            check(f_uv, 1'b0);
            wait_flag(1, 12);
            tick(2);
            check({f_uv, f_oc, pg_oe}, 3'h5);
            check({d0, d1, d2}, 6'h2A);
            restart_by(1'b0);
        end
        // Overvoltage clamp on a random output
        seed = lfsr_next(seed);
        k = seed % 3;
        @(posedge clk);
        ov_cmp <= 3'h1 << k;
        wait_flag(2, 6);
        tick(2);
        check({f_ov, pg_oe}, 2'h3);
        check({d0, d1, d2}, {ov_drv(0, k), ov_drv(1, k), ov_drv(2, k)});
        @(posedge clk);
        enable_in <= 1'b0;
        tick(4);
        @(posedge clk);
        enable_in <= 1'b1;
        tick(6);
        check({f_ov, go, pg_oe}, 3'h5);
        @(posedge clk);
        ov_cmp <= 3'h0;
        ov_clear_cmp <= 3'h1 << k;
        tick(5);
        check({d0, d1, d2}, 6'h2A);
        @(posedge clk);
        ov_clear_cmp <= 3'h0;
        ov_cmp <= 3'h1 << k;
        tick(5);
        check({d0, d1, d2}, {ov_drv(0, k), ov_drv(1, k), ov_drv(2, k)});
        restart_by(1'b1);
        check(f_ov, 1'b0);
        // Overvoltage still watched after an overcurrent latch
        @(posedge clk);
        core_sc_cmp <= 2'h1;
        wait_flag(0, 6);
        @(posedge clk);
        ov_cmp <= 3'h4;
        wait_flag(2, 6);
        check({f_ov, d2}, 3'h7);
        restart_by(1'b1);
        end_of_test();
    end
endmodule // tb
